// ### pdz_positioning_done.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - select 0: done while deviation is below the completion window.
// - select 1: done while no command and deviation below window.
// - select 2: done needs no command, zero speed and deviation below window.
// - select 3: flag latches on until next command, then holds for hold time.
// - select 3: after hold time expires, flag follows live command and deviation.
// - select 4: after commands stop, wait hold time, then evaluate no-command window.
// - hold time 0 to 15000 ms, default 0, used by latch mode and delay mode.
// - hold time 0 keeps latched flag on until the next command.
// - hold 1..15000 ms keeps flag on; a new command clears it at once.
// - zero-speed flag sets when speed is below threshold minus hysteresis, threshold 10..2000 RPM, default 50.
// - hysteresis 10 RPM: set below threshold-10, clear above threshold+10.
// - completion window is a settable deviation limit, 0..10000, default 10.
module pdz_positioning_done #(
  parameter int MS_CYCLES = pdz_pkg::MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire pdz_pkg::pdz_motion_t motion,
  output logic positioning_done_flag,
  output logic zero_speed_flag,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0] sel_reg, sel_next;
  logic [15:0] hold_reg, hold_next;
  logic [15:0] win_reg, win_next;
  logic [15:0] thr_reg, thr_next;
  logic [3:0] ists_reg, ists_next;
  logic [3:0] imask_reg, imask_next;
  logic [31:0] rd_reg, rd_next;
  logic irq_reg, irq_next;
  pdz_pkg::pdz_state_t st_reg, st_next;
  logic done_reg, done_next;
  logic cmd_d_reg;
  logic zs_d_reg;
  logic [15:0] pre_reg, pre_next;
  logic [15:0] ms_reg, ms_next;
  logic zs_flag;
  logic base_ok;
  logic in_window;
  logic cmd_rise;
  logic timer_run;
  logic [3:0] events;

  pdz_zero_speed u_zero_speed (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .motor_speed(motion.motor_speed),
    .threshold(thr_reg),
    .zero_speed_flag(zs_flag)
  );

  // ----------------------------------------------------------------
  // completion logic
  // ----------------------------------------------------------------
  always_comb
  begin
    in_window = motion.pos_dev_abs < {16'h0000, win_reg};
    base_ok = !motion.cmd_active && in_window;
    cmd_rise = motion.cmd_active && !cmd_d_reg;
    st_next = pdz_pkg::ST_LIVE;
    done_next = 1'b0;
    timer_run = 1'b0;
    case (sel_reg)
      pdz_pkg::COND_WINDOW:
      begin
        done_next = in_window;
      end
      pdz_pkg::COND_NO_CMD:
      begin
        done_next = base_ok;
      end
      pdz_pkg::COND_ZERO_SPD:
      begin
        done_next = base_ok && zs_flag;
      end
      pdz_pkg::COND_LATCH:
      begin
        case (st_reg)
          pdz_pkg::ST_LIVE:
          begin
            done_next = base_ok;
            st_next = base_ok ? pdz_pkg::ST_LATCH : pdz_pkg::ST_LIVE;
          end
          pdz_pkg::ST_LATCH:
          begin
            done_next = 1'b1;
            st_next = pdz_pkg::ST_LATCH;
            if (cmd_rise)
            begin
              // zero hold: the command itself ends the latch
              done_next = (hold_reg != 16'h0000);
              st_next = (hold_reg != 16'h0000) ? pdz_pkg::ST_HOLD : pdz_pkg::ST_LIVE;
            end
          end
          pdz_pkg::ST_HOLD:
          begin
            timer_run = 1'b1;
            done_next = 1'b1;
            st_next = pdz_pkg::ST_HOLD;
            if (cmd_rise)
            begin
              done_next = 1'b0;
              st_next = pdz_pkg::ST_LIVE;
            end
            else if (ms_reg >= hold_reg)
            begin
              done_next = base_ok;
              st_next = pdz_pkg::ST_LIVE;
            end
          end
          default:
          begin
            st_next = pdz_pkg::ST_LIVE;
          end
        endcase
      end
      pdz_pkg::COND_DELAY:
      begin
        // timer restarts whenever a command is present
        timer_run = !motion.cmd_active;
        done_next = base_ok && (ms_reg >= hold_reg);
      end
      default:
      begin
        done_next = in_window;
      end
    endcase
    pre_next = 16'h0000;
    ms_next = 16'h0000;
    if (timer_run)
    begin
      pre_next = (pre_reg == 16'(MS_CYCLES - 1)) ? 16'h0000 : 16'(pre_reg + 16'h0001);
      ms_next = ms_reg;
      if (pre_reg == 16'(MS_CYCLES - 1) && ms_reg != 16'hFFFF)
      begin
        ms_next = 16'(ms_reg + 16'h0001);
      end
    end
  end

  // ----------------------------------------------------------------
  // register bus and interrupts
  // ----------------------------------------------------------------
  always_comb
  begin
    sel_next = sel_reg;
    hold_next = hold_reg;
    win_next = win_reg;
    thr_next = thr_reg;
    imask_next = imask_reg;
    rd_next = 32'h0000_0000;
    events = 4'h0;
    events[pdz_pkg::IRQ_DONE_RISE] = done_reg && !positioning_done_flag;
    events[pdz_pkg::IRQ_DONE_FALL] = !done_reg && positioning_done_flag;
    events[pdz_pkg::IRQ_ZS_SET] = zs_flag && !zs_d_reg;
    events[pdz_pkg::IRQ_ZS_CLEAR] = !zs_flag && zs_d_reg;
    ists_next = ists_reg;
    if (wr_en)
    begin
      case (addr)
        pdz_pkg::ADDR_COND_SEL:
        begin
          // out-of-range selects are dropped, keeping the last legal one
          if (wr_data[15:0] <= {13'h0, pdz_pkg::COND_SEL_MAX})
            sel_next = wr_data[2:0];
        end
        pdz_pkg::ADDR_HOLD_TIME: hold_next = wr_data[15:0];
        pdz_pkg::ADDR_WINDOW: win_next = wr_data[15:0];
        pdz_pkg::ADDR_ZS_THRESHOLD: thr_next = wr_data[15:0];
        pdz_pkg::ADDR_IRQ_STATUS: ists_next = ists_reg & ~wr_data[3:0];
        pdz_pkg::ADDR_IRQ_MASK: imask_next = wr_data[3:0];
        default: ;
      endcase
    end
    // set beats clear in the same cycle
    ists_next = ists_next | events;
    if (rd_en)
    begin
      case (addr)
        pdz_pkg::ADDR_COND_SEL: rd_next = {29'h0, sel_reg};
        pdz_pkg::ADDR_HOLD_TIME: rd_next = {16'h0000, hold_reg};
        pdz_pkg::ADDR_WINDOW: rd_next = {16'h0000, win_reg};
        pdz_pkg::ADDR_ZS_THRESHOLD: rd_next = {16'h0000, thr_reg};
        pdz_pkg::ADDR_STATUS: rd_next = {28'h000_0000, st_reg, zero_speed_flag,
                                         positioning_done_flag};
        pdz_pkg::ADDR_IRQ_STATUS: rd_next = {28'h000_0000, ists_reg};
        pdz_pkg::ADDR_IRQ_MASK: rd_next = {28'h000_0000, imask_reg};
        default: rd_next = 32'h0000_0000;
      endcase
    end
    irq_next = |(ists_reg & imask_reg);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sel_reg <= pdz_pkg::RST_COND_SEL;
      hold_reg <= pdz_pkg::RST_HOLD_TIME;
      win_reg <= pdz_pkg::RST_WINDOW;
      thr_reg <= pdz_pkg::RST_ZS_THRESHOLD;
      ists_reg <= 4'h0;
      imask_reg <= pdz_pkg::RST_IRQ_MASK;
      rd_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      st_reg <= pdz_pkg::ST_LIVE;
      done_reg <= 1'b0;
      cmd_d_reg <= 1'b0;
      zs_d_reg <= 1'b0;
      pre_reg <= 16'h0000;
      ms_reg <= 16'h0000;
      positioning_done_flag <= 1'b0;
      zero_speed_flag <= 1'b0;
    end
    else
    begin
      sel_reg <= sel_next;
      hold_reg <= hold_next;
      win_reg <= win_next;
      thr_reg <= thr_next;
      ists_reg <= ists_next;
      imask_reg <= imask_next;
      rd_reg <= rd_next;
      irq_reg <= irq_next;
      st_reg <= st_next;
      done_reg <= done_next;
      cmd_d_reg <= motion.cmd_active;
      zs_d_reg <= zs_flag;
      pre_reg <= pre_next;
      ms_reg <= ms_next;
      positioning_done_flag <= done_reg;
      zero_speed_flag <= zs_flag;
    end
  end

  assign rd_data = rd_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mode0_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_reg == pdz_pkg::COND_WINDOW && in_window && !wr_en) |=> ##1 positioning_done_flag)
    else $error("select 0 did not report done inside window");

  a_mode1_cmd_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_reg == pdz_pkg::COND_NO_CMD && motion.cmd_active && !wr_en)
      |=> ##1 !positioning_done_flag)
    else $error("select 1 reported done during command");

  a_mode2_needs_zs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_reg == pdz_pkg::COND_ZERO_SPD && !zs_flag && !wr_en) |=> ##1 !positioning_done_flag)
    else $error("select 2 reported done without zero speed");

  a_latch_stays_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_reg == pdz_pkg::COND_LATCH && st_reg == pdz_pkg::ST_LATCH && !cmd_rise && !wr_en)
      |=> done_reg && st_reg == pdz_pkg::ST_LATCH)
    else $error("latched done flag dropped without command");

  a_hold_zero_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_reg == pdz_pkg::COND_LATCH && st_reg == pdz_pkg::ST_LATCH && cmd_rise
      && hold_reg == 16'h0000 && !wr_en) |=> !done_reg && st_reg == pdz_pkg::ST_LIVE)
    else $error("zero hold did not end latch on command");

  a_hold_cmd_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_reg == pdz_pkg::COND_LATCH && st_reg == pdz_pkg::ST_HOLD && cmd_rise && !wr_en)
      |=> !done_reg ##1 !positioning_done_flag)
    else $error("command during hold did not clear done");

  a_hold_expires: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_reg == pdz_pkg::COND_LATCH && st_reg == pdz_pkg::ST_HOLD && !cmd_rise
      && ms_reg >= hold_reg && !wr_en) |=> st_reg == pdz_pkg::ST_LIVE)
    else $error("hold time expiry did not return to live");

  a_mode4_waits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_reg == pdz_pkg::COND_DELAY && ms_reg < hold_reg && !wr_en) |=> !done_reg)
    else $error("select 4 reported done before delay");

  a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((ists_reg & imask_reg) != 4'h0) |=> irq)
    else $error("interrupt output missed a masked status bit");

  a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((ists_reg & imask_reg) == 4'h0) |=> !irq)
    else $error("interrupt output high with no masked status bit");

  a_sel_in_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sel_reg <= pdz_pkg::COND_SEL_MAX)
    else $error("completion select left its legal range");

endmodule

// ### pdz_pkg.sv
package pdz_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_COND_SEL = 16'h2400;
  localparam logic [15:0] ADDR_HOLD_TIME = 16'h2404;
  localparam logic [15:0] ADDR_WINDOW = 16'h2408;
  localparam logic [15:0] ADDR_STATUS = 16'h240C;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h2410;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h2414;
  localparam logic [15:0] ADDR_ZS_THRESHOLD = 16'h2434;

  // ----------------------------------------------------------------
  // values after reset, select limit and zero-speed hysteresis
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_COND_SEL = 3'h0;
  localparam logic [2:0] COND_SEL_MAX = 3'h4;
  localparam logic [15:0] RST_HOLD_TIME = 16'h0000;
  localparam logic [15:0] RST_WINDOW = 16'h000A;
  localparam logic [15:0] RST_ZS_THRESHOLD = 16'h0032;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  localparam logic [15:0] ZS_HYSTERESIS = 16'h000A;

  // ----------------------------------------------------------------
  // completion conditions and interrupt bit positions
  // ----------------------------------------------------------------
  localparam logic [2:0] COND_WINDOW = 3'h0;
  localparam logic [2:0] COND_NO_CMD = 3'h1;
  localparam logic [2:0] COND_ZERO_SPD = 3'h2;
  localparam logic [2:0] COND_LATCH = 3'h3;
  localparam logic [2:0] COND_DELAY = 3'h4;
  localparam int IRQ_DONE_RISE = 0;
  localparam int IRQ_DONE_FALL = 1;
  localparam int IRQ_ZS_SET = 2;
  localparam int IRQ_ZS_CLEAR = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_LIVE = 2'b00,
    ST_LATCH = 2'b01,
    ST_HOLD = 2'b10
  } pdz_state_t;

  typedef struct packed {
    logic cmd_active;
    logic [31:0] pos_dev_abs;
    logic signed [15:0] motor_speed;
  } pdz_motion_t;

endpackage

// ### pdz_zero_speed.sv
`timescale 1ns/100ps
module pdz_zero_speed (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic signed [15:0] motor_speed,
  input wire logic [15:0] threshold,
  output logic zero_speed_flag
);

  logic [15:0] mag;
  logic [15:0] lo_lim;
  logic [16:0] hi_lim;
  logic zs_next;

  always_comb
  begin
    // -32768 maps to 0x8000 as unsigned, so no overflow
    mag = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
    // thresholds under the band would wrap, so floor at zero
    lo_lim = (threshold > pdz_pkg::ZS_HYSTERESIS) ? 16'(threshold - pdz_pkg::ZS_HYSTERESIS)
                                                   : 16'h0000;
    hi_lim = {1'b0, threshold} + {1'b0, pdz_pkg::ZS_HYSTERESIS};
    zs_next = zero_speed_flag;
    if (mag < lo_lim)
    begin
      zs_next = 1'b1;
    end
    else if ({1'b0, mag} > hi_lim)
    begin
      zs_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      zero_speed_flag <= 1'b0;
    else
      zero_speed_flag <= zs_next;
  end

  a_zs_set_below: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mag < lo_lim) |=> zero_speed_flag)
    else $error("zero speed flag not set below band");

  a_zs_clear_above: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ({1'b0, mag} > hi_lim) |=> !zero_speed_flag)
    else $error("zero speed flag not cleared above band");

  a_zs_band_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mag >= lo_lim && {1'b0, mag} <= hi_lim) |=> $stable(zero_speed_flag))
    else $error("zero speed flag moved inside band");

endmodule

// ### pdz_ctrl_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// motion controller side: drives command, deviation, speed
// ----------------------------------------
module pdz_ctrl_model (
  input wire logic sys_clk,
  input wire logic positioning_done_flag,
  output pdz_pkg::pdz_motion_t motion
);
  initial motion = '0;
  // bounded wait for the done flag, n counts the clock edges spent
  task automatic wait_done(input logic v, input int lim, output int n);
    n = 0;
    while (positioning_done_flag !== v && n < lim)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic drive(input logic cmd, input logic [31:0] dev,
                       input logic signed [15:0] spd);
    @(posedge sys_clk);
    motion <= '{cmd_active: cmd, pos_dev_abs: dev, motor_speed: spd};
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
      miscompares++; \
    end \
  end
module tb_top;
  // ----------------------------------------
  // clock, reset, bus
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  pdz_pkg::pdz_motion_t motion;
  logic positioning_done_flag;
  logic zero_speed_flag;
  logic irq;
  int miscompares = 0;
  int check_count = 0;
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // short ms so hold and delay runs stay brief
  pdz_positioning_done #(.MS_CYCLES(4)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .motion(motion), .positioning_done_flag(positioning_done_flag),
    .zero_speed_flag(zero_speed_flag), .irq(irq));
  pdz_ctrl_model ctrl_u (.sys_clk(sys_clk), .positioning_done_flag(positioning_done_flag),
    .motion(motion));
  task automatic end_of_test;
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd_expect(input logic [15:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data, e)
  endtask
  task automatic mv(input logic cmd, input logic [31:0] dev, input logic signed [15:0] spd);
    ctrl_u.drive(cmd, dev, spd);
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_done(input logic v, input int lim, output int n);
    ctrl_u.wait_done(v, lim, n);
    if (positioning_done_flag !== v)
    begin
      miscompares++;
      end_of_test();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_expect(pdz_pkg::ADDR_COND_SEL, 32'h0);
    rd_expect(pdz_pkg::ADDR_HOLD_TIME, 32'h0);
    rd_expect(pdz_pkg::ADDR_WINDOW, 32'h0000000A);
    rd_expect(pdz_pkg::ADDR_ZS_THRESHOLD, 32'h00000032);
    rd_expect(16'h2420, 32'h0);
    wr(pdz_pkg::ADDR_COND_SEL, 32'h5);
    rd_expect(pdz_pkg::ADDR_COND_SEL, 32'h0);
  endtask
  task automatic t_sel01;
    mv(1'b1, 32'h9, 16'sd0);
    `CHK(positioning_done_flag, 1'b1)
    mv(1'b1, 32'hA, 16'sd0);
    `CHK(positioning_done_flag, 1'b0)
    wr(pdz_pkg::ADDR_WINDOW, 32'h20);
    mv(1'b1, 32'h1F, 16'sd0);
    `CHK(positioning_done_flag, 1'b1)
    wr(pdz_pkg::ADDR_COND_SEL, 32'h1);
    mv(1'b1, 32'h1F, 16'sd0);
    `CHK(positioning_done_flag, 1'b0)
    mv(1'b0, 32'h1F, 16'sd0);
    `CHK(positioning_done_flag, 1'b1)
  endtask
  task automatic t_zero_speed;
    `CHK(zero_speed_flag, 1'b1)
    mv(1'b0, 32'h0, 16'sd50);
    `CHK(zero_speed_flag, 1'b1)
    mv(1'b0, 32'h0, 16'sd61);
    `CHK(zero_speed_flag, 1'b0)
    mv(1'b0, 32'h0, 16'sd45);
    `CHK(zero_speed_flag, 1'b0)
    mv(1'b0, 32'h0, -16'sd39);
    `CHK(zero_speed_flag, 1'b1)
    mv(1'b0, 32'h0, -16'sd61);
    `CHK(zero_speed_flag, 1'b0)
    wr(pdz_pkg::ADDR_ZS_THRESHOLD, 32'h64);
    mv(1'b0, 32'h0, 16'sd85);
    `CHK(zero_speed_flag, 1'b1)
  endtask
  task automatic t_sel2;
    wr(pdz_pkg::ADDR_COND_SEL, 32'h2);
    mv(1'b0, 32'h0, 16'sd85);
    `CHK(positioning_done_flag, 1'b1)
    mv(1'b0, 32'h0, 16'sd200);
    `CHK(positioning_done_flag, 1'b0)
    mv(1'b1, 32'h0, 16'sd0);
    `CHK(positioning_done_flag, 1'b0)
  endtask
  task automatic t_latch;
    int n;
    wr(pdz_pkg::ADDR_COND_SEL, 32'h3);
    wr(pdz_pkg::ADDR_HOLD_TIME, 32'h2);
    mv(1'b0, 32'h0, 16'sd0);
    mv(1'b0, 32'h500, 16'sd0);
    `CHK(positioning_done_flag, 1'b1)
    rd_expect(pdz_pkg::ADDR_STATUS, 32'h00000007);
    mv(1'b1, 32'h500, 16'sd0);
    `CHK(positioning_done_flag, 1'b1)
    wait_done(1'b0, 40, n);
    // 2 ms of 4 cycles each after the command, plus the two-stage output path
    `CHK(n >= 6 && n <= 8, 1'b1)
    mv(1'b0, 32'h0, 16'sd0);
    `CHK(positioning_done_flag, 1'b1)
    mv(1'b1, 32'h500, 16'sd0);
    ctrl_u.drive(1'b0, 32'h500, 16'sd0);
    mv(1'b1, 32'h500, 16'sd0);
    `CHK(positioning_done_flag, 1'b0)
    wr(pdz_pkg::ADDR_HOLD_TIME, 32'h0);
    mv(1'b0, 32'h0, 16'sd0);
    mv(1'b0, 32'h500, 16'sd0);
    repeat (40) @(posedge sys_clk);
    #1;
    `CHK(positioning_done_flag, 1'b1)
    mv(1'b1, 32'h0, 16'sd0);
    `CHK(positioning_done_flag, 1'b0)
  endtask
  task automatic t_delay;
    int n;
    wr(pdz_pkg::ADDR_COND_SEL, 32'h4);
    wr(pdz_pkg::ADDR_HOLD_TIME, 32'h2);
    mv(1'b1, 32'h0, 16'sd0);
    mv(1'b0, 32'h0, 16'sd0);
    `CHK(positioning_done_flag, 1'b0)
    wait_done(1'b1, 30, n);
    `CHK(n >= 6 && n <= 8, 1'b1)
  endtask
  task automatic t_irq;
    wr(pdz_pkg::ADDR_COND_SEL, 32'h0);
    mv(1'b0, 32'h500, 16'sd0);
    wr(pdz_pkg::ADDR_IRQ_STATUS, 32'hF);
    wr(pdz_pkg::ADDR_IRQ_MASK, 32'h1);
    rd_expect(pdz_pkg::ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(irq, 1'b0)
    mv(1'b0, 32'h0, 16'sd0);
    `CHK(irq, 1'b1)
    rd_expect(pdz_pkg::ADDR_IRQ_STATUS, 32'h1);
    wr(pdz_pkg::ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(irq, 1'b0)
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_sel01();
    t_zero_speed();
    t_sel2();
    t_latch();
    t_delay();
    t_irq();
    end_of_test();
  end
endmodule
